/* logic/level_capture.sv */
`timescale 1ns/1ps
module level_capture
    import set_point_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ck_level,
    input  wire logic [1:0]  dqs_t_pin,
    input  wire logic        active,
    output logic      [15:0] dq_o,
    output logic      [15:0] dq_oe
);

    logic [1:0] dqs_s1_q;
    logic [1:0] dqs_s2_q;
    logic [1:0] dqs_s3_q;
    logic [1:0] fb_q;
    logic [1:0] valid_q;
    logic [1:0] rise;

    ////////////////////////////////////////////////////////////////////////
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++) begin : g_lane
            assign rise[lane] = dqs_s2_q[lane] & ~dqs_s3_q[lane];

            // Lanes share nothing but the sampled clock level and the active flag
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    dqs_s1_q[lane] <= 1'b0;
                    dqs_s2_q[lane] <= 1'b0;
                    dqs_s3_q[lane] <= 1'b0;
                    fb_q[lane]     <= 1'b0;
                    valid_q[lane]  <= 1'b0;
                end else begin
                    dqs_s1_q[lane] <= dqs_t_pin[lane];
                    dqs_s2_q[lane] <= dqs_s1_q[lane];
                    dqs_s3_q[lane] <= dqs_s2_q[lane];
                    if (!active) begin
                        valid_q[lane] <= 1'b0;
                    end else if (rise[lane]) begin
                        fb_q[lane]    <= ck_level;
                        valid_q[lane] <= 1'b1;
                    end
                end
            end

            assign dq_o[lane*8 +: 8]  = {8{fb_q[lane]}};
            assign dq_oe[lane*8 +: 8] = {8{valid_q[lane]}};

            property p_feedback;
                @(posedge clk) disable iff (rst)
                active && rise[lane] |=>
                    dq_o[lane*8 +: 8] == {8{$past(ck_level)}}
                    && dq_oe[lane*8 +: 8] == 8'hFF;
            endproperty
            a_feedback: assert property (p_feedback)
                else $error("feedback not presented after strobe edge");

            property p_undriven;
                @(posedge clk) disable iff (rst)
                !active |=> dq_oe[lane*8 +: 8] == 8'h00;
            endproperty
            a_undriven: assert property (p_undriven)
                else $error("data driven outside leveling");

            property p_independent;
                @(posedge clk) disable iff (rst)
                active && !rise[lane] && $past(active) |=>
                    $stable(fb_q[lane]);
            endproperty
            a_independent: assert property (p_independent)
                else $error("lane feedback changed without own edge");

            c_edge: cover property (@(posedge clk) disable iff (rst)
                active && rise[lane] ##1 dq_oe[lane*8]);
        end
    endgenerate

endmodule : level_capture

/* logic/set_point_pkg.sv */
package set_point_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int SW_LONG_NS      = 250;
    localparam int SW_LONG_CYC_I   =
        (SW_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SW_LONG_CYC = 8'(SW_LONG_CYC_I);
    localparam int LEVEL_OUT_MAX_NS = 20;
    localparam int LEVEL_OUT_CYC    =
        (LEVEL_OUT_MAX_NS / CLK_PERIOD_NS < 1) ?
            1 : LEVEL_OUT_MAX_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Avalon register map, byte addresses
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_SHORT  = 5'h04;
    localparam logic [4:0] REG_MIDDLE = 5'h08;
    localparam logic [4:0] REG_VREF0  = 5'h0C;
    localparam logic [4:0] REG_VREF1  = 5'h10;

    // Status fields
    localparam int ST_OP    = 0;
    localparam int ST_ACC   = 1;
    localparam int ST_BUSY  = 2;
    localparam int ST_LEVEL = 3;
    localparam int ST_PERR  = 4;
    localparam int ST_VREF_CURRENT_GENERATOR_MODE  = 5;
    localparam int ST_CLS   = 8;

    ////////////////////////////////////////////////////////////////////////
    // Mode register addresses and operand bits
    localparam logic [5:0] MA_LEVEL = 6'h02;
    localparam logic [5:0] MA_VREF  = 6'h0C;
    localparam logic [5:0] MA_SETPT = 6'h0D;
    localparam int OPB_OP_SEL = 7;
    localparam int OPB_ACC    = 6;
    localparam int OPB_VREF_CURRENT_GENERATOR_MODE   = 3;
    localparam int OPB_LEVEL  = 7;
    localparam int OPB_RANGE  = 6;

    // Reset values
    localparam logic [7:0] SETPT_RST  = 8'h00;
    localparam logic [6:0] VREF_RST   = 7'h4D;
    localparam logic [7:0] SHORT_RST  = 8'h04;
    localparam logic [7:0] MIDDLE_RST = 8'h08;

    typedef enum logic [1:0] {
        CMD_DESELECT,
        CMD_MRW,
        CMD_OTHER,
        CMD_RSVD
    } cmd_kind_t;

    typedef enum logic [1:0] {
        CLS_SHORT,
        CLS_MIDDLE,
        CLS_LONG
    } switch_class_t;

endpackage : set_point_pkg

/* logic/set_point_switch.sv */
`timescale 1ns/1ps
// Behaviour
// - Range differs between set points: long switch time, 250 ns.
// - Same range, setting one step apart: short switch time.
// - Same range, setting two or more steps apart: middle time.
// - Device starts on set point 0 with low-frequency defaults.
// - One select write switches set point; host waits switch time.
// - Leveling bit written one enters leveling, zero leaves it.
// - Strobe rise samples clock level onto every bit of its byte.
// - Data pins undefined on leveling entry until feedback exists.
// - Each strobe lane levels independently of the other.
// - Each edge overwrites captured level; shown within output delay.
// - Clock may stop or change rate during leveling.
// - Operating select bit picks which parameter copy is used.
// - Access select bit picks which copy mode writes reach.
module set_point_switch
    import set_point_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ck_pin,
    input  wire logic [1:0]  cmd_kind_pin,
    input  wire logic [5:0]  cmd_ma_pin,
    input  wire logic [7:0]  cmd_op_pin,
    input  wire logic [1:0]  dqs_t_pin,
    output logic      [15:0] dq_o,
    output logic      [15:0] dq_oe,
    output logic             op_set_point,
    output logic             switch_busy,
    output logic             leveling_active,
    output logic             protocol_error
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [15:0]   cmd_s1_q;
    logic [15:0]   cmd_s2_q;
    logic          ck_s1_q;
    logic          ck_s2_q;
    logic          ck_s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_s1_q <= 16'h0000;
            cmd_s2_q <= 16'h0000;
            ck_s1_q  <= 1'b0;
            ck_s2_q  <= 1'b0;
            ck_s3_q  <= 1'b0;
        end else begin
            cmd_s1_q <= {cmd_kind_pin, cmd_ma_pin, cmd_op_pin};
            cmd_s2_q <= cmd_s1_q;
            ck_s1_q  <= ck_pin;
            ck_s2_q  <= ck_s1_q;
            ck_s3_q  <= ck_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode, taken on each sampled clock rise
    logic [7:0]    setpt_q;
    logic [6:0]    vref_q [2];
    logic [7:0]    short_q;
    logic [7:0]    middle_q;
    logic [7:0]    count_q;
    logic          busy_q;
    logic          level_q;
    logic          perr_q;
    switch_class_t cls_q;

    wire           ck_rise  = ck_s2_q & ~ck_s3_q;
    wire cmd_kind_t kind    = cmd_kind_t'(cmd_s2_q[15:14]);
    wire [5:0]     ma       = cmd_s2_q[13:8];
    wire [7:0]     op       = cmd_s2_q[7:0];
    wire           is_mrw   = ck_rise && kind == CMD_MRW;
    wire           mrw_lvl  = is_mrw && ma == MA_LEVEL;
    wire           mrw_vref = is_mrw && ma == MA_VREF;
    wire           mrw_setp = is_mrw && ma == MA_SETPT;
    wire           cur_sel  = setpt_q[OPB_OP_SEL];
    wire           acc_sel  = setpt_q[OPB_ACC];
    wire           new_sel  = op[OPB_OP_SEL];
    wire           sw_start = mrw_setp && new_sel != cur_sel;

    // Switch time class from both vref copies, either direction
    wire [6:0]     vref_old = vref_q[cur_sel];
    wire [6:0]     vref_new = vref_q[new_sel];
    wire           rng_diff = vref_old[OPB_RANGE] ^ vref_new[OPB_RANGE];
    wire [6:0]     step     = {1'b0, vref_old[5:0]} - {1'b0, vref_new[5:0]};
    wire           step_one = step == 7'h01 || step == 7'h7F;
    wire           step_0   = step == 7'h00;
    wire switch_class_t cls =
        rng_diff           ? CLS_LONG   :
        (step_one | step_0) ? CLS_SHORT :
                             CLS_MIDDLE;
    wire [7:0]     cls_cyc  =
        cls == CLS_LONG  ? SW_LONG_CYC :
        cls == CLS_SHORT ? short_q : middle_q;

    // Only a deselect or a write to the leveling register, of either value, is legal in leveling
    wire           perr_set = level_q && ck_rise &&
                              (kind == CMD_OTHER || kind == CMD_RSVD ||
                               (kind == CMD_MRW && ma != MA_LEVEL));

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait state on every access
    logic          wait_q;
    logic [31:0]   rdata_q;

    wire           req      = avs_read | avs_write;
    wire           sw_wr    = avs_write && !wait_q;
    wire           wr_stat  = sw_wr && avs_address == REG_STATUS;
    wire           wr_short = sw_wr && avs_address == REG_SHORT;
    wire           wr_mid   = sw_wr && avs_address == REG_MIDDLE;
    wire           perr_clr = wr_stat && avs_writedata[ST_PERR];
    // A zero wait would defeat the switch guard, so clamp to one cycle
    wire [7:0]     wr_cyc   = avs_writedata[7:0] == 8'h00 ? 8'h01
                                                          : avs_writedata[7:0];
    wire [31:0]    status   = {22'h000000, cls_q, 2'h0,
                               setpt_q[OPB_VREF_CURRENT_GENERATOR_MODE], perr_q, level_q,
                               busy_q, acc_sel, cur_sel};
    wire [31:0]    rd_mux   =
        avs_address == REG_STATUS ? status                  :
        avs_address == REG_SHORT  ? {24'h000000, short_q}   :
        avs_address == REG_MIDDLE ? {24'h000000, middle_q}  :
        avs_address == REG_VREF0  ? {25'h0000000, vref_q[0]} :
        avs_address == REG_VREF1  ? {25'h0000000, vref_q[1]} :
                                    32'h00000000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= !(req && wait_q);
            if (avs_read && wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            short_q  <= SHORT_RST;
            middle_q <= MIDDLE_RST;
        end else begin
            if (wr_short) begin
                short_q <= wr_cyc;
            end
            if (wr_mid) begin
                middle_q <= wr_cyc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode registers and set point switch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setpt_q   <= SETPT_RST;
            vref_q[0] <= VREF_RST;
            vref_q[1] <= VREF_RST;
        end else begin
            if (mrw_setp) begin
                setpt_q <= op;
            end
            if (mrw_vref) begin
                vref_q[acc_sel] <= op[6:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 8'h00;
            cls_q   <= CLS_SHORT;
            busy_q  <= 1'b0;
        end else if (sw_start) begin
            count_q <= cls_cyc;
            cls_q   <= cls;
            busy_q  <= 1'b1;
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
            busy_q  <= count_q != 8'h01;
        end
    end

    assign op_set_point = setpt_q[OPB_OP_SEL];
    assign switch_busy  = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Write leveling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
            perr_q  <= 1'b0;
        end else begin
            if (mrw_lvl) begin
                level_q <= op[OPB_LEVEL];
            end
            // Set wins over a clear in the same cycle
            perr_q <= perr_set | (perr_q & ~perr_clr);
        end
    end

    assign leveling_active = level_q;
    assign protocol_error  = perr_q;

    level_capture u_capture (
        .clk       (clk),
        .rst       (rst),
        .ck_level  (ck_s2_q),
        .dqs_t_pin (dqs_t_pin),
        .active    (level_q),
        .dq_o      (dq_o),
        .dq_oe     (dq_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic          seen_setp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_setp_q <= 1'b0;
        end else if (mrw_setp) begin
            seen_setp_q <= 1'b1;
        end
    end

    property p_reset_point;
        @(posedge clk) disable iff (rst)
        !seen_setp_q |-> !op_set_point && vref_q[1] == VREF_RST;
    endproperty
    a_reset_point: assert property (p_reset_point)
        else $error("device left set point 0 without a select write");

    property p_long;
        @(posedge clk) disable iff (rst)
        sw_start && (vref_q[0][6] != vref_q[1][6]) |->
            ##10 switch_busy ##1 !switch_busy;
    endproperty
    a_long: assert property (p_long)
        else $error("long switch time not applied");

    property p_short;
        @(posedge clk) disable iff (rst)
        sw_start && vref_q[0][6] == vref_q[1][6] &&
            ({1'b0, vref_q[0][5:0]} - {1'b0, vref_q[1][5:0]} == 7'h01 ||
             {1'b0, vref_q[1][5:0]} - {1'b0, vref_q[0][5:0]} == 7'h01)
        |=> cls_q == CLS_SHORT && count_q == short_q;
    endproperty
    a_short: assert property (p_short)
        else $error("single step did not select short switch time");

    property p_middle;
        @(posedge clk) disable iff (rst)
        sw_start && vref_q[0][6] == vref_q[1][6] &&
            {1'b0, vref_q[0][5:0]} - {1'b0, vref_q[1][5:0]} != 7'h01 &&
            {1'b0, vref_q[1][5:0]} - {1'b0, vref_q[0][5:0]} != 7'h01 &&
            vref_q[0][5:0] != vref_q[1][5:0]
        |=> cls_q == CLS_MIDDLE && count_q == middle_q;
    endproperty
    a_middle: assert property (p_middle)
        else $error("multi step did not select middle switch time");

    property p_switch;
        @(posedge clk) disable iff (rst)
        mrw_setp |=> op_set_point == $past(op[OPB_OP_SEL])
                     ##1 $stable(op_set_point) || $past(mrw_setp);
    endproperty
    a_switch: assert property (p_switch)
        else $error("select write did not switch set point");

    property p_access;
        @(posedge clk) disable iff (rst)
        mrw_vref |=> $past(acc_sel)
            ? vref_q[1] == $past(op[6:0]) && $stable(vref_q[0])
            : vref_q[0] == $past(op[6:0]) && $stable(vref_q[1]);
    endproperty
    a_access: assert property (p_access)
        else $error("mode write reached the wrong copy");

    property p_level;
        @(posedge clk) disable iff (rst)
        mrw_lvl |=> leveling_active == $past(op[OPB_LEVEL]);
    endproperty
    a_level: assert property (p_level)
        else $error("leveling bit did not set leveling state");

    property p_perr;
        @(posedge clk) disable iff (rst)
        leveling_active && ck_rise && kind == CMD_OTHER |=>
            protocol_error [*2];
    endproperty
    a_perr: assert property (p_perr)
        else $error("illegal command in leveling not flagged");

    c_long: cover property (@(posedge clk) disable iff (rst)
        sw_start && cls == CLS_LONG);
    c_short: cover property (@(posedge clk) disable iff (rst)
        sw_start && cls == CLS_SHORT);
    c_exit: cover property (@(posedge clk) disable iff (rst)
        leveling_active ##1 !leveling_active);

endmodule : set_point_switch

/* verification/host_model.sv */
`timescale 1ns/1ps
module host_model
    import set_point_pkg::*;
(
    input  wire logic       clk,
    output logic            ck_pin,
    output logic      [1:0] cmd_kind_pin,
    output logic      [5:0] cmd_ma_pin,
    output logic      [7:0] cmd_op_pin,
    output logic      [1:0] dqs_t_pin
);
    // Half of a 200 ns link period at the 25 ns system clock
    localparam int HALF = 4;

    initial begin
        ck_pin       = 1'b0;
        cmd_kind_pin = CMD_DESELECT;
        cmd_ma_pin   = 6'h00;
        cmd_op_pin   = 8'h00;
        dqs_t_pin    = 2'b00;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic ck_run(input int n);
        repeat (n) begin
            @(posedge clk);
            ck_pin <= 1'b1;
            repeat (HALF) @(posedge clk);
            ck_pin <= 1'b0;
            repeat (HALF - 1) @(posedge clk);
        end
    endtask : ck_run

    // Pins held a full half period either side of the rising edge
    task automatic send(input cmd_kind_t k, input logic [5:0] ma,
                        input logic [7:0] op);
        ck_run(4);
        @(posedge clk);
        cmd_kind_pin <= k;
        cmd_ma_pin   <= ma;
        cmd_op_pin   <= op;
        repeat (HALF) @(posedge clk);
        ck_pin <= 1'b1;
        repeat (HALF) @(posedge clk);
        ck_pin       <= 1'b0;
        cmd_kind_pin <= CMD_DESELECT;
        // Released bus shows no stale operand
        cmd_ma_pin   <= ~ma;
        cmd_op_pin   <= ~op;
        ck_run(4);
    endtask : send

    // Clock parked at lvl so the sampled level is known
    task automatic burst(input logic [1:0] lanes, input logic lvl);
        ck_run(20);
        @(posedge clk);
        ck_pin <= lvl;
        repeat (HALF) @(posedge clk);
        repeat (2) begin
            dqs_t_pin <= lanes;
            repeat (HALF) @(posedge clk);
            dqs_t_pin <= 2'b00;
            repeat (HALF) @(posedge clk);
        end
        ck_run(4);
    endtask : burst
endmodule : host_model

/* verification/set_point_switch_tb_top.sv */
`timescale 1ns/1ps
module set_point_switch_tb_top;
    import set_point_pkg::*;

    logic        clk;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ck_pin;
    logic [1:0]  cmd_kind_pin;
    logic [5:0]  cmd_ma_pin;
    logic [7:0]  cmd_op_pin;
    logic [1:0]  dqs_t_pin;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic        op_set_point;
    logic        switch_busy;
    logic        leveling_active;
    logic        protocol_error;
    int          fails;
    int          num_checks;
    logic [7:0]  busy_cnt;
    logic [7:0]  last_len;
    logic [7:0]  short_c;
    logic [7:0]  mid_c;
    logic [6:0]  vref_m [2];
    logic        cur;
    logic [31:0] rd;

    set_point_switch set_point_switch_inst (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ck_pin(ck_pin),
        .cmd_kind_pin(cmd_kind_pin), .cmd_ma_pin(cmd_ma_pin),
        .cmd_op_pin(cmd_op_pin), .dqs_t_pin(dqs_t_pin), .dq_o(dq_o),
        .dq_oe(dq_oe), .op_set_point(op_set_point),
        .switch_busy(switch_busy), .leveling_active(leveling_active),
        .protocol_error(protocol_error)
    );

    host_model host_model_inst (
        .clk(clk), .ck_pin(ck_pin), .cmd_kind_pin(cmd_kind_pin),
        .cmd_ma_pin(cmd_ma_pin), .cmd_op_pin(cmd_op_pin),
        .dqs_t_pin(dqs_t_pin)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Length of the last busy run, seen from outside the design
    always @(posedge clk) begin
        if (switch_busy === 1'b1) begin
            busy_cnt <= busy_cnt + 8'h01;
        end else if (busy_cnt != 8'h00) begin
            last_len <= busy_cnt;
            busy_cnt <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic switch_class_t cls_of(input logic [6:0] a,
                                             input logic [6:0] b);
        int d;
        d = int'(a[5:0]) - int'(b[5:0]);
        if (a[6] != b[6]) return CLS_LONG;
        if (d <= 1 && d >= -1) return CLS_SHORT;
        return CLS_MIDDLE;
    endfunction : cls_of

    function automatic logic [7:0] cyc_of(input switch_class_t c);
        case (c)
            CLS_SHORT:  return short_c;
            CLS_MIDDLE: return mid_c;
            default:    return SW_LONG_CYC;
        endcase
    endfunction : cyc_of

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic av(input bit wr, input logic [4:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : av

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        fails = 0;
        num_checks = 0;
        busy_cnt = 8'h00;
        last_len = 8'h00;
        void'($urandom(8780));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({op_set_point, leveling_active, protocol_error, dq_oe}, 0);
        av(0, REG_STATUS, 0);
        chk(rd[5:0], 0);
        av(0, REG_VREF0, 0);
        chk(rd, {25'h0, VREF_RST});
        av(0, REG_VREF1, 0);
        chk(rd, {25'h0, VREF_RST});
        av(0, REG_SHORT, 0);
        chk(rd, {24'h0, SHORT_RST});
        av(0, REG_MIDDLE, 0);
        chk(rd, {24'h0, MIDDLE_RST});
        av(1, 5'h14, 32'hFFFFFFFF);
        av(0, 5'h14, 0);
        chk(rd, 0);
        av(1, REG_SHORT, 0);
        av(0, REG_SHORT, 0);
        chk(rd, 1);
        vref_m[0] = VREF_RST;
        vref_m[1] = VREF_RST;
        cur = 1'b0;
        for (int i = 0; i < 6; i++) begin
            int s;
            int d;
            logic [6:0] nv;
            switch_class_t c;
            short_c = 8'(1 + $urandom % 30);
            mid_c = 8'(1 + $urandom % 30);
            av(1, REG_SHORT, {24'h0, short_c});
            av(1, REG_MIDDLE, {24'h0, mid_c});
            nv = vref_m[cur];
            s = int'(nv[5:0]);
            d = (i % 3 == 0) ? 1 : 2 + int'($urandom % 5);
            if (i % 3 == 2) nv = {~nv[6], 6'($urandom)};
            else if (s >= d && ($urandom % 2 == 1 || s + d > 63))
                nv[5:0] = 6'(s - d);
            else nv[5:0] = 6'(s + d);
            // Retarget writes to the idle copy, then reload it
            host_model_inst.send(CMD_MRW, MA_SETPT, {cur, ~cur, 6'h00});
            host_model_inst.send(CMD_MRW, MA_VREF, {1'b0, nv});
            vref_m[~cur] = nv;
            c = cls_of(vref_m[0], vref_m[1]);
            host_model_inst.send(CMD_MRW, MA_SETPT, {~cur, ~cur, 6'h08});
            cur = ~cur;
            repeat (300) begin
                @(posedge clk);
                if (switch_busy === 1'b0) break;
            end
            @(posedge clk);
            chk(last_len, cyc_of(c));
            chk(op_set_point, cur);
            av(0, REG_STATUS, 0);
            chk({rd[9:8], rd[5], rd[0]}, {c, 1'b1, cur});
            host_model_inst.send(CMD_MRW, MA_SETPT, {cur, cur, 6'h00});
        end
        av(0, REG_VREF0, 0);
        chk(rd, {25'h0, vref_m[0]});
        av(0, REG_VREF1, 0);
        chk(rd, {25'h0, vref_m[1]});
        host_model_inst.send(CMD_MRW, MA_LEVEL, 8'h80);
        chk({leveling_active, dq_oe}, {1'b1, 16'h0});
        host_model_inst.ck_run(40);
        for (int j = 0; j < 4; j++) begin
            logic l0;
            logic l1;
            l0 = 1'(j);
            l1 = 1'($urandom);
            host_model_inst.burst(2'b01, l0);
            if (j == 0) begin
                chk({dq_oe, dq_o[7:0]}, {16'h00FF, {8{l0}}});
            end
            host_model_inst.burst(2'b10, l1);
            chk({dq_oe, dq_o}, {16'hFFFF, {8{l1}}, {8{l0}}});
        end
        host_model_inst.send(CMD_OTHER, 6'h00, 8'h00);
        chk(protocol_error, 1);
        av(1, REG_STATUS, 32'h10);
        @(posedge clk);
        chk(protocol_error, 0);
        host_model_inst.send(CMD_MRW, MA_VREF, 8'h00);
        chk(protocol_error, 1);
        av(1, REG_STATUS, 32'h10);
        host_model_inst.send(CMD_RSVD, 6'h00, 8'h00);
        av(0, REG_STATUS, 0);
        chk({rd[4], rd[3]}, 2'b11);
        host_model_inst.send(CMD_MRW, MA_LEVEL, 8'h00);
        chk({leveling_active, dq_oe}, 0);
        print_verdict();
    end
endmodule : set_point_switch_tb_top
